// ---- verilog/pafi_pkg.sv ----
// Purpose: Shared constants for the partition feature identification register bank.
// Assumes: One 32-bit word per register, byte offsets within a feature page.
// Notes:   Identification values themselves are parameters of the top module.

package pafi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address map
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam int          NUM_SPACES = 4;
  localparam int          SPACE_W    = 2;
  localparam logic [11:0] OFF_SECURE_ID_LIMITS    = 12'h008;
  localparam logic [11:0] OFF_PRIORITY_FEATURE_ID = 12'h048;
  localparam logic [11:0] OFF_CACHE_ASSOC_LIMIT   = 12'h118;

  // Security space codes on the access port
  localparam logic [1:0] SPACE_SECURE    = 2'h0;
  localparam logic [1:0] SPACE_NONSECURE = 2'h1;
  localparam logic [1:0] SPACE_ROOT      = 2'h2;
  localparam logic [1:0] SPACE_REALM     = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Priority feature register fields
  localparam int WD_W          = 6;
  localparam int PRI_WD_MAX    = 16;
  localparam int DS_WD_LSB     = 20;
  localparam int DS_WD_MSB     = 25;
  localparam int DS_LOW_BIT    = 17;
  localparam int DS_HAS_BIT    = 16;
  localparam int INT_WD_LSB    = 4;
  localparam int INT_WD_MSB    = 9;
  localparam int INT_LOW_BIT   = 1;
  localparam int INT_HAS_BIT   = 0;
  localparam logic [31:0] PRI_RSVD_MASK = 32'hfc0c_fc0c;

  // Secure limit register fields
  localparam int SGRP_LSB  = 16;
  localparam int SGRP_MSB  = 23;
  localparam int SPART_LSB = 0;
  localparam int SPART_MSB = 15;
  localparam int SID_RSVD_LSB = 24;
  localparam int SID_RSVD_MSB = 31;

  // Associativity fraction field
  localparam int          ASSOC_W    = 16;
  localparam logic [15:0] ASSOC_FULL = 16'hffff;
  localparam logic [15:0] ASSOC_RESET = 16'h0000;

endpackage : pafi_pkg

// ---- verilog/pafi_store_if.sv ----
// Purpose: Carries access and limit signals between the bank and its limit store.
// Assumes: Single clock; the bank drives selectors, the store answers combinationally.
// Notes:   Limit words are stored already masked to the implemented bits.

`timescale 1ns/100ps
`default_nettype none

interface pafi_store_if #(
  parameter int PART_W = 4,
  parameter int INST_W = 1
);
  // Write port
  logic                         wr_en;
  logic [pafi_pkg::SPACE_W-1:0] wr_space;
  logic [INST_W-1:0]            wr_inst;
  logic [PART_W-1:0]            wr_part;
  logic [pafi_pkg::ASSOC_W-1:0] wr_data;
  // Read port
  logic [pafi_pkg::SPACE_W-1:0] rd_space;
  logic [INST_W-1:0]            rd_inst;
  logic [PART_W-1:0]            rd_part;
  logic [pafi_pkg::ASSOC_W-1:0] rd_data;
  // Per-space selected limits
  logic [pafi_pkg::NUM_SPACES-1:0][INST_W-1:0]            lim_inst;
  logic [pafi_pkg::NUM_SPACES-1:0][PART_W-1:0]            lim_part;
  logic [pafi_pkg::NUM_SPACES-1:0][pafi_pkg::ASSOC_W-1:0] lim_data;

  modport bank  (output wr_en, wr_space, wr_inst, wr_part, wr_data,
                 output rd_space, rd_inst, rd_part, lim_inst, lim_part,
                 input  rd_data, lim_data);
  modport store (input  wr_en, wr_space, wr_inst, wr_part, wr_data,
                 input  rd_space, rd_inst, rd_part, lim_inst, lim_part,
                 output rd_data, lim_data);
endinterface : pafi_store_if

`default_nettype wire

// ---- verilog/pafi_assoc_store.sv ----
// Purpose: Holds the associativity limit of every space, instance and partition.
// Assumes: Write data arrives unmasked; masking happens here on entry.
// Notes:   Reset clears every limit; reads are combinational from the array.

`timescale 1ns/100ps
`default_nettype none

module pafi_assoc_store #(
  parameter int PART_W   = 4,
  parameter int INST_W   = 1,
  parameter int ASSOC_WD = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Bank side
  pafi_store_if.store sif
);

  localparam int NINST = 1 << INST_W;
  localparam int NPART = 1 << PART_W;
  // Implemented bits are the top ASSOC_WD bits of the fraction
  localparam logic [15:0] IMPL_MASK = ~(pafi_pkg::ASSOC_FULL >> ASSOC_WD);

  typedef struct packed {
    logic [pafi_pkg::NUM_SPACES-1:0][NINST-1:0][NPART-1:0][pafi_pkg::ASSOC_W-1:0] mem;
  } pafi_store_state_t;

  pafi_store_state_t st_q;
  pafi_store_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: one word written per cycle, low bits dropped
  always_comb begin
    st_d = st_q;
    if (sif.wr_en) begin
      st_d.mem[sif.wr_space][sif.wr_inst][sif.wr_part] = sif.wr_data & IMPL_MASK;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Read ports
  assign sif.rd_data = st_q.mem[sif.rd_space][sif.rd_inst][sif.rd_part];

  // One limit per space, each following its own selector
  for (genvar s = 0; s < pafi_pkg::NUM_SPACES; s++) begin : g_lim
    assign sif.lim_data[s] = st_q.mem[s][sif.lim_inst[s]][sif.lim_part[s]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unimplemented low bits never read back as ones
  a_store_low_bits: assert property (@(posedge clk) disable iff (!resetn)
    (sif.rd_data & ~IMPL_MASK) == '0)
    else $error("associativity low bits not zero");

endmodule : pafi_assoc_store

`default_nettype wire

// ---- verilog/pafi_regs.sv ----
// Purpose: Priority feature, secure limit and associativity limit registers per space.
// Assumes: One access per cycle; a request is answered on the next clock edge.
// Notes:   Identification contents are fixed by parameters and never change.
//
// How it works
// - Bits 25:20 give downstream priority width, 1..16 if present, else zero.
// - Bit 17 set means downstream value zero is the lowest priority.
// - Bit 16 set only when the downstream priority field exists.
// - Bits 9:4 give internal priority width, 1..16 if present, else zero.
// - Bit 1 set means internal value zero is the lowest priority.
// - Bit 0 set only when the internal priority field exists.
// - Instance fields follow the selected instance; others are instance independent.
// - Priority feature register reads zero, ignores writes, without priority partitioning.
// - A read-only priority feature copy sits at 0x0048 of each space page.
// - Root and realm copies are readable only with realm management present.
// - Secure limit register reports the secure group limit in bits 23:16.
// - Secure partition limit in bits 15:0; bits 31:24 read zero.
// - Secure limit is read-only, secure page 0x0008 only, absent without secure map.
// - Associativity limit is read/write and caps the selected partition's ways.
// - Each space keeps its own limit, keyed by its own partition selector.
// - With instance selection, limit accesses go to selected instance and partition.
// - Limit register exists only with capacity, minor version and associativity support.
// - Fraction in bits 15:0, top bits implemented, others read zero.
// - Associativity limit sits at 0x0118 of every space page.

`timescale 1ns/100ps
`default_nettype none

module pafi_regs #(
  parameter int PART_W = 4,
  parameter int INST_W = 1,
  parameter bit INST_SELECT_PRESENT    = 1'b1,
  parameter bit PRIORITY_PART_PRESENT  = 1'b1,
  parameter bit REALM_MGMT_PRESENT     = 1'b1,
  parameter bit SECURE_MAP_PRESENT     = 1'b1,
  parameter bit CAPACITY_PART_PRESENT  = 1'b1,
  parameter bit MINOR_VERSION_PRESENT  = 1'b1,
  parameter bit ASSOC_LIMIT_PRESENT    = 1'b1,
  parameter int ASSOC_WD               = 8,
  parameter logic [7:0]  SECURE_GROUP_LIMIT     = 8'h03,
  parameter logic [15:0] SECURE_PARTITION_LIMIT = 16'h000f,
  parameter logic [(1<<INST_W)-1:0][5:0] DS_PRIORITY_WIDTH  = {(1<<INST_W){6'h04}},
  parameter logic [(1<<INST_W)-1:0]      DS_ZERO_LOWEST     = '0,
  parameter logic [(1<<INST_W)-1:0][5:0] INT_PRIORITY_WIDTH = {(1<<INST_W){6'h03}},
  parameter logic [(1<<INST_W)-1:0]      INT_ZERO_LOWEST    = '1
) (
  // Clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   resetn,
  // Register access
  input  wire logic                                   req,
  input  wire logic                                   req_we,
  input  wire logic [pafi_pkg::SPACE_W-1:0]           req_space,
  input  wire logic [pafi_pkg::ADDR_W-1:0]            req_addr,
  input  wire logic [pafi_pkg::DATA_W-1:0]            req_wdata,
  output var  logic                                   ack_q,
  output var  logic [pafi_pkg::DATA_W-1:0]            rdata_q,
  // Partition selectors, one per space
  input  wire logic [pafi_pkg::NUM_SPACES-1:0][PART_W-1:0] selected_partition,
  input  wire logic [pafi_pkg::NUM_SPACES-1:0][INST_W-1:0] resource_instance_select,
  // Limits applied by the cache allocator, one per space
  output var  logic [pafi_pkg::NUM_SPACES-1:0][pafi_pkg::ASSOC_W-1:0] assoc_limit_q
);

  typedef struct packed {
    logic                                               ack;
    logic [pafi_pkg::DATA_W-1:0]                        rdata;
    logic [pafi_pkg::NUM_SPACES-1:0][pafi_pkg::ASSOC_W-1:0] limit;
    // Last access, kept for checking the answer
    logic                                               last_we;
    logic [pafi_pkg::SPACE_W-1:0]                       last_space;
    logic [pafi_pkg::ADDR_W-1:0]                        last_addr;
  } pafi_regs_state_t;

  pafi_regs_state_t st_q;
  pafi_regs_state_t st_d;

  pafi_store_if #(.PART_W(PART_W), .INST_W(INST_W)) sif ();

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Root and realm pages exist only with realm management
  function automatic logic space_ok(input logic [pafi_pkg::SPACE_W-1:0] sp);
    space_ok = ((sp != pafi_pkg::SPACE_ROOT) && (sp != pafi_pkg::SPACE_REALM))
               || REALM_MGMT_PRESENT;
  endfunction : space_ok

  // Instance index; without instance selection every access sees instance zero
  function automatic logic [INST_W-1:0] inst_of(input logic [pafi_pkg::SPACE_W-1:0] sp);
    inst_of = INST_SELECT_PRESENT ? resource_instance_select[sp] : '0;
  endfunction : inst_of

  // Builds one priority feature word; presence bits come from the widths
  function automatic logic [31:0] pri_word(input logic [INST_W-1:0] inst);
    logic [31:0] w;
    w = '0;
    w[pafi_pkg::DS_WD_MSB:pafi_pkg::DS_WD_LSB]   = DS_PRIORITY_WIDTH[inst];
    w[pafi_pkg::DS_LOW_BIT]                      = DS_ZERO_LOWEST[inst];
    w[pafi_pkg::DS_HAS_BIT]                      = (DS_PRIORITY_WIDTH[inst] != '0);
    w[pafi_pkg::INT_WD_MSB:pafi_pkg::INT_WD_LSB] = INT_PRIORITY_WIDTH[inst];
    w[pafi_pkg::INT_LOW_BIT]                     = INT_ZERO_LOWEST[inst];
    w[pafi_pkg::INT_HAS_BIT]                     = (INT_PRIORITY_WIDTH[inst] != '0);
    pri_word = w;
  endfunction : pri_word

  // Limit register exists only with all three features
  localparam bit ASSOC_OK = CAPACITY_PART_PRESENT && MINOR_VERSION_PRESENT
                            && ASSOC_LIMIT_PRESENT;

  // Secure limit word, fixed at build time
  localparam logic [31:0] SID_WORD = {8'h00, SECURE_GROUP_LIMIT, SECURE_PARTITION_LIMIT};

  ////////////////////////////////////////////////////////////////////////////
  // Store connections: the accessing space's own selector picks the entry
  always_comb begin
    sif.wr_en    = req && req_we && (req_addr == pafi_pkg::OFF_CACHE_ASSOC_LIMIT)
                   && ASSOC_OK && space_ok(req_space);
    sif.wr_space = req_space;
    sif.wr_inst  = inst_of(req_space);
    sif.wr_part  = selected_partition[req_space];
    sif.wr_data  = req_wdata[pafi_pkg::ASSOC_W-1:0];
    sif.rd_space = req_space;
    sif.rd_inst  = inst_of(req_space);
    sif.rd_part  = selected_partition[req_space];
  end

  // Each space's live limit follows that space's selector
  for (genvar s = 0; s < pafi_pkg::NUM_SPACES; s++) begin : g_sel
    assign sif.lim_inst[s] = INST_SELECT_PRESENT ? resource_instance_select[s] : '0;
    assign sif.lim_part[s] = selected_partition[s];
  end

  pafi_assoc_store #(
    .PART_W   (PART_W),
    .INST_W   (INST_W),
    .ASSOC_WD (ASSOC_WD)
  ) u_store (
    .clk    (clk),
    .resetn (resetn),
    .sif    (sif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: reads answer next cycle; writes answer with zero data
  always_comb begin
    st_d            = st_q;
    st_d.ack        = req;
    st_d.rdata      = '0;
    st_d.last_we    = req_we;
    st_d.last_space = req_space;
    st_d.last_addr  = req_addr;
    if (req && !req_we) begin
      case (req_addr)
        pafi_pkg::OFF_PRIORITY_FEATURE_ID: begin
          if (PRIORITY_PART_PRESENT && space_ok(req_space)) begin
            st_d.rdata = pri_word(inst_of(req_space));
          end
        end
        pafi_pkg::OFF_SECURE_ID_LIMITS: begin
          if (SECURE_MAP_PRESENT && (req_space == pafi_pkg::SPACE_SECURE)) begin
            st_d.rdata = SID_WORD;
          end
        end
        pafi_pkg::OFF_CACHE_ASSOC_LIMIT: begin
          if (ASSOC_OK && space_ok(req_space)) begin
            st_d.rdata = {16'h0000, sif.rd_data};
          end
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end
    // Limits are re-registered so the allocator sees clean flop outputs
    st_d.limit = sif.lim_data;
  end

  // State register; writes to read-only offsets simply fall through
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign ack_q         = st_q.ack;
  assign rdata_q       = st_q.rdata;
  assign assoc_limit_q = st_q.limit;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_ack_next_cycle: assert property (@(posedge clk) disable iff (!resetn)
    req |=> ack_q)
    else $error("access not answered on next cycle");

  a_pri_rsvd_zero: assert property (@(posedge clk) disable iff (!resetn)
    (ack_q && (st_q.last_addr == pafi_pkg::OFF_PRIORITY_FEATURE_ID))
    |-> ((rdata_q & pafi_pkg::PRI_RSVD_MASK) == '0))
    else $error("priority feature reserved bits set");

  a_pri_ds_present: assert property (@(posedge clk) disable iff (!resetn)
    (ack_q && (st_q.last_addr == pafi_pkg::OFF_PRIORITY_FEATURE_ID) && (rdata_q != '0))
    |-> (rdata_q[pafi_pkg::DS_HAS_BIT]
         == (rdata_q[pafi_pkg::DS_WD_MSB:pafi_pkg::DS_WD_LSB] != '0)))
    else $error("downstream presence disagrees with width");

  a_pri_int_present: assert property (@(posedge clk) disable iff (!resetn)
    (ack_q && (st_q.last_addr == pafi_pkg::OFF_PRIORITY_FEATURE_ID) && (rdata_q != '0))
    |-> (rdata_q[pafi_pkg::INT_HAS_BIT]
         == (rdata_q[pafi_pkg::INT_WD_MSB:pafi_pkg::INT_WD_LSB] != '0)))
    else $error("internal presence disagrees with width");

  a_pri_width_range: assert property (@(posedge clk) disable iff (!resetn)
    (ack_q && (st_q.last_addr == pafi_pkg::OFF_PRIORITY_FEATURE_ID))
    |-> ((rdata_q[pafi_pkg::DS_WD_MSB:pafi_pkg::DS_WD_LSB] <= pafi_pkg::PRI_WD_MAX)
         && (rdata_q[pafi_pkg::INT_WD_MSB:pafi_pkg::INT_WD_LSB] <= pafi_pkg::PRI_WD_MAX)))
    else $error("priority width above sixteen");

  a_pri_absent_zero: assert property (@(posedge clk) disable iff (!resetn)
    (ack_q && (st_q.last_addr == pafi_pkg::OFF_PRIORITY_FEATURE_ID)
     && (!PRIORITY_PART_PRESENT || !space_ok(st_q.last_space)))
    |-> (rdata_q == '0))
    else $error("absent priority feature register not zero");

  a_sid_top_zero: assert property (@(posedge clk) disable iff (!resetn)
    (ack_q && (st_q.last_addr == pafi_pkg::OFF_SECURE_ID_LIMITS))
    |-> (rdata_q[pafi_pkg::SID_RSVD_MSB:pafi_pkg::SID_RSVD_LSB] == '0))
    else $error("secure limit top byte not zero");

  a_sid_secure_only: assert property (@(posedge clk) disable iff (!resetn)
    (req && !req_we && (req_addr == pafi_pkg::OFF_SECURE_ID_LIMITS)
     && (req_space != pafi_pkg::SPACE_SECURE))
    |=> (ack_q && (rdata_q == '0)))
    else $error("secure limit visible outside secure page");

  a_sid_values: assert property (@(posedge clk) disable iff (!resetn)
    (req && !req_we && (req_addr == pafi_pkg::OFF_SECURE_ID_LIMITS)
     && (req_space == pafi_pkg::SPACE_SECURE) && SECURE_MAP_PRESENT)
    |=> ((rdata_q[pafi_pkg::SGRP_MSB:pafi_pkg::SGRP_LSB] == SECURE_GROUP_LIMIT)
         && (rdata_q[pafi_pkg::SPART_MSB:pafi_pkg::SPART_LSB] == SECURE_PARTITION_LIMIT)))
    else $error("secure limit fields wrong");

  a_write_no_data: assert property (@(posedge clk) disable iff (!resetn)
    (ack_q && st_q.last_we) |-> (rdata_q == '0))
    else $error("write answered with data");

  a_assoc_readback: assert property (@(posedge clk) disable iff (!resetn)
    (req && req_we && (req_addr == pafi_pkg::OFF_CACHE_ASSOC_LIMIT) && ASSOC_OK
     && space_ok(req_space))
    ##1 (req && !req_we && (req_addr == pafi_pkg::OFF_CACHE_ASSOC_LIMIT)
         && (req_space == $past(req_space)) && $stable(selected_partition)
         && $stable(resource_instance_select))
    |=> (rdata_q[pafi_pkg::ASSOC_W-1:0]
         == ($past(req_wdata[pafi_pkg::ASSOC_W-1:0], 2)
             & ~(pafi_pkg::ASSOC_FULL >> ASSOC_WD))))
    else $error("associativity limit did not read back");

  a_assoc_absent: assert property (@(posedge clk) disable iff (!resetn)
    (ack_q && (st_q.last_addr == pafi_pkg::OFF_CACHE_ASSOC_LIMIT) && !ASSOC_OK)
    |-> (rdata_q == '0))
    else $error("absent associativity limit not zero");

endmodule : pafi_regs

`default_nettype wire

// ---- sim/test_partition_feature_id_regs.sv ----
// Purpose: Self-checking bench for the partition feature identification register bank.
// Assumes: Every request is answered exactly one cycle later, as the port contract gives.
// Notes:   A second instance without priority partitioning, realm management, secure map or associativity limit shares the stimulus.

`timescale 1ns/100ps
`default_nettype none

module test_partition_feature_id_regs;

  ////////////////////////////////////////////////////////////////////////////
  // Identification values, chosen to differ per instance
  localparam int              AWD    = 8;
  localparam logic [15:0]     AMSK   = 16'hffff << (16 - AWD);
  localparam logic [7:0]      SGL    = 8'h5a;
  localparam logic [15:0]     SPL    = 16'h0123;
  localparam logic [1:0][5:0] DS_WD  = {6'h10, 6'h04};
  localparam logic [1:0]      DS_LO  = 2'h2;
  localparam logic [1:0][5:0] INT_WD = {6'h00, 6'h03};
  localparam logic [1:0]      INT_LO = 2'h1;

  logic             clk       = 1'b0;
  logic             resetn    = 1'b0;
  logic             req       = 1'b0;
  logic             req_we    = 1'b0;
  logic [1:0]       req_space = 2'h0;
  logic [11:0]      req_addr  = 12'h000;
  logic [31:0]      req_wdata = 32'h0000_0000;
  logic [3:0][3:0]  sel_part  = 16'h0000;
  logic [3:0][0:0]  sel_inst  = 4'h0;
  logic             ack_q;
  logic             bare_ack;
  logic [31:0]      rdata_q;
  logic [31:0]      bare_rdata;
  logic [3:0][15:0] assoc_limit_q;
  logic [3:0][15:0] bare_limit;
  logic [31:0]      exp_q[$];
  logic [15:0]      lim[4][2][16];
  int               n_fail    = 0;
  int               compares  = 0;

  // Half period of a 40 MHz clock
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Fully featured instance and a bare one without priority, realm, secure map or associativity limit
  pafi_regs #(
    .ASSOC_WD(AWD), .SECURE_GROUP_LIMIT(SGL), .SECURE_PARTITION_LIMIT(SPL),
    .DS_PRIORITY_WIDTH(DS_WD), .DS_ZERO_LOWEST(DS_LO),
    .INT_PRIORITY_WIDTH(INT_WD), .INT_ZERO_LOWEST(INT_LO)
  ) i_dut (
    .clk(clk), .resetn(resetn), .req(req), .req_we(req_we), .req_space(req_space),
    .req_addr(req_addr), .req_wdata(req_wdata), .ack_q(ack_q), .rdata_q(rdata_q),
    .selected_partition(sel_part), .resource_instance_select(sel_inst),
    .assoc_limit_q(assoc_limit_q)
  );

  pafi_regs #(
    .PRIORITY_PART_PRESENT(1'b0), .REALM_MGMT_PRESENT(1'b0),
    .SECURE_MAP_PRESENT(1'b0), .ASSOC_LIMIT_PRESENT(1'b0)
  ) i_dut_bare (
    .clk(clk), .resetn(resetn), .req(req), .req_we(req_we), .req_space(req_space),
    .req_addr(req_addr), .req_wdata(req_wdata), .ack_q(bare_ack), .rdata_q(bare_rdata),
    .selected_partition(sel_part), .resource_instance_select(sel_inst),
    .assoc_limit_q(bare_limit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] pri_word(input int i);
    pri_word = {6'h00, DS_WD[i], 2'h0, DS_LO[i], DS_WD[i] != 6'h00,
                6'h00, INT_WD[i], 2'h0, INT_LO[i], INT_WD[i] != 6'h00};
  endfunction : pri_word

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // One request per call; back-to-back calls keep req high
  task automatic acc(input logic we, input logic [1:0] sp, input logic [11:0] ad,
                     input logic [31:0] wd, input logic [31:0] exp);
    @(posedge clk);
    #2;
    req       = 1'b1;
    req_we    = we;
    req_space = sp;
    req_addr  = ad;
    req_wdata = wd;
    exp_q.push_back(exp);
  endtask : acc

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
      req = 1'b0;
    end
  endtask : idle

  // Narrow partition range so random traffic revisits stored limits
  task automatic new_sel;
    idle(1);
    for (int k = 0; k < 4; k++) begin
      sel_part[k] = 4'($urandom_range(3));
      sel_inst[k] = 1'($urandom);
    end
  endtask : new_sel

  task automatic check_limits;
    idle(3);
    for (int s = 0; s < 4; s++) begin
      check({16'h0, assoc_limit_q[s]}, {16'h0, lim[s][sel_inst[s]][sel_part[s]]});
      check({16'h0, bare_limit[s]}, 32'h0);
    end
  endtask : check_limits

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: takes the oldest note whenever an answer appears
  always @(posedge clk) begin
    #1;
    // Every request is answered exactly one cycle later, by both instances
    check({31'h0, ack_q}, {31'h0, req});
    check({31'h0, bare_ack}, {31'h0, req});
    if (bare_ack === 1'b1) check(bare_rdata, 32'h0);
    if (ack_q === 1'b1) begin
      if (exp_q.size() > 0) begin
        check(rdata_q, exp_q.pop_front());
      end else begin
        n_fail++;
        $display("wrong value at %0t ns: answer without request", $time);
      end
    end else begin
      check(rdata_q, 32'h0);
    end
  end

  // Watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int          s;
    logic [31:0] d;
    void'($urandom(72));
    lim = '{default: '0};
    repeat (20) @(posedge clk);
    #2;
    resetn = 1'b1;
    // Identification words from every page, both instances, writes ignored
    for (int i = 0; i < 2; i++) begin
      idle(1);
      sel_inst = {4{i[0]}};
      for (int t = 0; t < 4; t++) begin
        acc(1'b0, 2'(t), 12'h048, 32'h0, pri_word(i));
        acc(1'b1, 2'(t), 12'h048, $urandom, 32'h0);
        acc(1'b0, 2'(t), 12'h048, 32'h0, pri_word(i));
        acc(1'b0, 2'(t), 12'h008, 32'h0, (t == 0) ? {8'h00, SGL, SPL} : 32'h0);
        acc(1'b1, 2'(t), 12'h008, 32'hffff_ffff, 32'h0);
        acc(1'b0, 2'(t), 12'h008, 32'h0, (t == 0) ? {8'h00, SGL, SPL} : 32'h0);
        acc(1'b0, 2'(t), 12'h04c, 32'h0, 32'h0);
      end
    end
    // Random limit traffic across spaces, instances and partitions
    for (int n = 0; n < 40; n++) begin
      new_sel;
      s = $urandom_range(3);
      d = $urandom;
      acc(1'b1, 2'(s), 12'h118, d, 32'h0);
      lim[s][sel_inst[s]][sel_part[s]] = d[15:0] & AMSK;
      // Read straight back so the write-then-read check has work to do
      acc(1'b0, 2'(s), 12'h118, 32'h0, {16'h0, lim[s][sel_inst[s]][sel_part[s]]});
      for (int t = 0; t < 4; t++) begin
        acc(1'b0, 2'(t), 12'h118, $urandom, {16'h0, lim[t][sel_inst[t]][sel_part[t]]});
      end
      check_limits;
    end
    // Reset in mid-run clears every stored limit
    resetn = 1'b0;
    lim = '{default: '0};
    repeat (3) @(posedge clk);
    #2;
    resetn = 1'b1;
    check_limits;
    for (int t = 0; t < 4; t++) begin
      acc(1'b0, 2'(t), 12'h118, 32'h0, 32'h0);
      acc(1'b0, 2'(t), 12'h048, 32'h0, pri_word(sel_inst[t]));
    end
    idle(3);
    check(32'(exp_q.size()), 32'h0);
    tally_and_finish;
  end

endmodule : test_partition_feature_id_regs

`default_nettype wire
